// *** core/int_lp_pkg.sv ***
// constants for the interrupt and low-power controller
package int_lp_pkg;
  // source indices, priority order (0 highest)
  localparam int NUM_SRC      = 11;
  localparam int SRC_PWD      = 0;
  localparam int SRC_HIGH     = 1;
  localparam int SRC_LVL_B    = 2;
  localparam int SRC_LVL_A    = 3;
  localparam int SRC_SP0_TX   = 4;
  localparam int SRC_SP0_RX   = 5;
  localparam int SRC_EDGE     = 6;
  localparam int SRC_BYTE_DMA     = 7;
  localparam int SRC_SP1_TX   = 8;
  localparam int SRC_SP1_RX   = 9;
  localparam int SRC_TIMER    = 10;
  // vectors
  localparam logic [15:0] VEC_RESET  = 16'h0000;
  localparam logic [15:0] VEC_PWD    = 16'h002C;
  localparam logic [15:0] VEC_HIGH   = 16'h0004;
  localparam logic [15:0] VEC_LVL_B  = 16'h0008;
  localparam logic [15:0] VEC_LVL_A  = 16'h000C;
  localparam logic [15:0] VEC_SP0_TX = 16'h0010;
  localparam logic [15:0] VEC_SP0_RX = 16'h0014;
  localparam logic [15:0] VEC_EDGE   = 16'h0018;
  localparam logic [15:0] VEC_BYTE_DMA   = 16'h001C;
  localparam logic [15:0] VEC_SP1_TX = 16'h0020;
  localparam logic [15:0] VEC_SP1_RX = 16'h0024;
  localparam logic [15:0] VEC_TIMER  = 16'h0028;
  // control register fields
  localparam int CTL_SENSE_ALT_A = 0;
  localparam int CTL_SENSE_ALT_B = 1;
  localparam int CTL_SENSE_HIGH  = 2;
  localparam int CTL_NEST        = 4;
  localparam int CTL_W           = 5;
  // reset values
  localparam logic [NUM_SRC-1:0] MASK_RESET  = 11'h000;
  localparam logic [CTL_W-1:0]   CTL_RESET   = 5'h00;
  localparam logic [6:0]         MODE_STATUS_REG_RESET = 7'h00;
  localparam int STACK_DEPTH = 12;
  // wake delays in input-clock cycles; core clock is twice that rate
  localparam int WAKE_FAST_INPUT_CLOCK_PIN = 400;
  localparam int WAKE_XTAL_INPUT_CLOCK_PIN = 4096;
  localparam int CORE_PER_INPUT_CLOCK_PIN  = 2;
  localparam int WAKE_FAST_CYC   = WAKE_FAST_INPUT_CLOCK_PIN * CORE_PER_INPUT_CLOCK_PIN;
  localparam int WAKE_XTAL_CYC   = WAKE_XTAL_INPUT_CLOCK_PIN * CORE_PER_INPUT_CLOCK_PIN;
  // slow idle divisor codes
  localparam logic [2:0] DIV_NONE = 3'h0;
  localparam logic [2:0] DIV_16   = 3'h1;
  localparam logic [2:0] DIV_32   = 3'h2;
  localparam logic [2:0] DIV_64   = 3'h3;
  localparam logic [2:0] DIV_128  = 3'h4;
  localparam logic [7:0] RATIO_1   = 8'h01;
  localparam logic [7:0] RATIO_16  = 8'h10;
  localparam logic [7:0] RATIO_32  = 8'h20;
  localparam logic [7:0] RATIO_64  = 8'h40;
  localparam logic [7:0] RATIO_128 = 8'h80;
endpackage

// *** core/pin_sync.sv ***
// two-stage synchroniser with falling-edge detect for one interrupt pin
`timescale 1ns/10ps
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pin side
  input  wire logic pin_n,
  // core side
  output logic      level,
  output logic      fall
);
  logic meta;
  logic stable;
  logic prev;

  // pins idle high, so reset the chain to high to avoid a false edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta   <= 1'b1;
      stable <= 1'b1;
      prev   <= 1'b1;
    end else begin
      meta   <= pin_n;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level = ~stable;
  assign fall  = prev & ~stable;
endmodule

// *** core/status_stack.sv ***
// twelve-deep status stack, registered read data
`timescale 1ns/10ps
module status_stack #(
  parameter int W     = 7,
  parameter int DEPTH = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // control
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  // status
  output logic      [W-1:0] top_data,
  output logic              empty,
  output logic              full
);
  localparam int PW = $clog2(DEPTH + 1);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] ptr;

  assign empty = (ptr == '0);
  assign full  = (ptr == PW'(DEPTH));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr <= '0;
    end else if (push && !full) begin
      ptr <= ptr + 1'b1;
    end else if (pop && !empty) begin
      ptr <= ptr - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem[ptr] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      top_data <= '0;
    end else if (push && !full) begin
      top_data <= push_data;
    end else if (pop && !empty) begin
      // track the new top so the next pop restores the right word
      top_data <= (ptr > PW'(1)) ? mem[ptr - PW'(2)] : '0;
    end
  end
endmodule

// *** core/dsp_interrupt_low_power_ctrl.sv ***
// interrupt prioritiser, vectoring, nesting and low-power control
`timescale 1ns/10ps
module dsp_interrupt_low_power_ctrl
  import int_lp_pkg::*;
#(
  parameter int WAKE_FAST = WAKE_FAST_CYC,
  parameter int WAKE_XTAL = WAKE_XTAL_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // external pins, active low except the sp1_data_rx data input
  input  wire logic                high_ext_interrupt_n,
  input  wire logic                level_interrupt_a_n,
  input  wire logic                level_interrupt_b_n,
  input  wire logic                edge_interrupt_n,
  input  wire logic                sp1_frame_rx_n,
  input  wire logic                sp1_frame_tx_n,
  input  wire logic                sp1_data_rx,
  input  wire logic                powerdown_request_pin_n,
  // internal requests, one-cycle pulses
  input  wire logic                sp0_tx_req,
  input  wire logic                sp0_rx_req,
  input  wire logic                byte_dma_req,
  input  wire logic                sp1_tx_req,
  input  wire logic                sp1_rx_req,
  input  wire logic                timer_req,
  // second serial port as interrupt pins
  input  wire logic                sp1_as_irq,
  input  wire logic                flag_out_value,
  output logic                     flag_in,
  output logic                     sp1_data_tx,
  // core register writes
  input  wire logic                mask_wr,
  input  wire logic [NUM_SRC-1:0]  mask_wdata,
  input  wire logic                ctl_wr,
  input  wire logic [CTL_W-1:0]    ctl_wdata,
  input  wire logic                force_clear_wr,
  input  wire logic [NUM_SRC-1:0]  force_bits,
  input  wire logic [NUM_SRC-1:0]  clear_bits,
  input  wire logic                global_int_enable_instr,
  input  wire logic                global_int_disable_instr,
  input  wire logic                mode_status_reg_wr,
  input  wire logic [6:0]          mode_status_reg_wdata,
  // core sequencing
  input  wire logic                int_return,
  input  wire logic                idle_instr,
  input  wire logic [2:0]          idle_div,
  input  wire logic                wake_context_select,
  input  wire logic                osc_off_in_pd,
  // to core
  output logic                     int_take,
  output logic [15:0]              int_vector,
  output logic                     core_run,
  output logic                     core_clk_en,
  output logic [7:0]               clk_div_ratio,
  output logic                     context_clear,
  output logic                     powerdown_ack,
  output logic [NUM_SRC-1:0]       interrupt_mask_reg,
  output logic [CTL_W-1:0]         interrupt_control_reg,
  output logic [6:0]               mode_status_reg,
  output logic                     global_enable,
  output logic                     stack_full
);
  typedef enum {RUN, IDLE, PD_ENTER, PD_SLEEP, PD_WAKE} lp_state_e;

  lp_state_e           state;
  logic [NUM_SRC-1:0]  pending;
  logic [NUM_SRC-1:0]  active;
  logic [NUM_SRC-1:0]  edge_latch;
  logic [NUM_SRC-1:0]  req;
  logic [NUM_SRC-1:0]  masked;
  logic [NUM_SRC-1:0]  sel_onehot;
  logic [NUM_SRC-1:0]  preempt_ok;
  logic                mask_block;
  logic                any_sel;
  logic [15:0]         next_vector;
  logic [13:0]         wake_cnt;
  logic [7:0]          div_cnt;
  logic                stk_empty;
  logic [6:0]          stk_top;

  // synchronised pins
  logic lvl_high, fall_high, lvl_a, lvl_b, fall_edge;
  logic lvl_alt_a, fall_alt_a, lvl_alt_b, fall_alt_b, fall_pwd;
  pin_sync u_high (.clk(clk), .sys_rst(sys_rst), .pin_n(high_ext_interrupt_n),
                   .level(lvl_high), .fall(fall_high));
  pin_sync u_lva  (.clk(clk), .sys_rst(sys_rst), .pin_n(level_interrupt_a_n),
                   .level(lvl_a), .fall());
  pin_sync u_lvb  (.clk(clk), .sys_rst(sys_rst), .pin_n(level_interrupt_b_n),
                   .level(lvl_b), .fall());
  pin_sync u_edge (.clk(clk), .sys_rst(sys_rst), .pin_n(edge_interrupt_n),
                   .level(), .fall(fall_edge));
  pin_sync u_alta (.clk(clk), .sys_rst(sys_rst), .pin_n(sp1_frame_rx_n),
                   .level(lvl_alt_a), .fall(fall_alt_a));
  pin_sync u_altb (.clk(clk), .sys_rst(sys_rst), .pin_n(sp1_frame_tx_n),
                   .level(lvl_alt_b), .fall(fall_alt_b));
  pin_sync u_pwd  (.clk(clk), .sys_rst(sys_rst), .pin_n(powerdown_request_pin_n),
                   .level(), .fall(fall_pwd));

  // flag pins when the second port is repurposed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_in     <= 1'b0;
      sp1_data_tx <= 1'b0;
    end else begin
      flag_in     <= sp1_as_irq ? sp1_data_rx : 1'b0;
      sp1_data_tx <= sp1_as_irq ? flag_out_value : 1'b0;
    end
  end

  // edge events per source; software force rides on the same latch
  logic [NUM_SRC-1:0] edge_evt;
  always_comb begin
    edge_evt = '0;
    edge_evt[SRC_PWD]    = fall_pwd & (state != PD_SLEEP); // a wake edge is no new request
    edge_evt[SRC_HIGH]   = fall_high & interrupt_control_reg[CTL_SENSE_HIGH];
    edge_evt[SRC_EDGE]   = fall_edge;
    edge_evt[SRC_SP0_TX] = sp0_tx_req;
    edge_evt[SRC_SP0_RX] = sp0_rx_req;
    edge_evt[SRC_BYTE_DMA]   = byte_dma_req;
    edge_evt[SRC_TIMER]  = timer_req;
    edge_evt[SRC_SP1_TX] = sp1_as_irq ? (fall_alt_b & interrupt_control_reg[CTL_SENSE_ALT_B])
                                      : sp1_tx_req;
    edge_evt[SRC_SP1_RX] = sp1_as_irq ? (fall_alt_a & interrupt_control_reg[CTL_SENSE_ALT_A])
                                      : sp1_rx_req;
  end

  // latches: set wins over software clear and over acceptance
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_latch <= '0;
    end else begin
      edge_latch <= (edge_latch & ~(force_clear_wr ? clear_bits : '0) & ~(int_take ? sel_onehot : '0))
                    | edge_evt | ((force_clear_wr ? force_bits : '0)
                    & ~(NUM_SRC'(state == PD_SLEEP) << SRC_PWD));
    end
  end

  // level-sensitive terms do not latch
  always_comb begin
    pending = edge_latch;
    pending[SRC_LVL_A] = lvl_a;
    pending[SRC_LVL_B] = lvl_b;
    if (!interrupt_control_reg[CTL_SENSE_HIGH]) begin
      pending[SRC_HIGH] = lvl_high;
    end
    if (sp1_as_irq && !interrupt_control_reg[CTL_SENSE_ALT_B]) begin
      pending[SRC_SP1_TX] = lvl_alt_b;
    end
    if (sp1_as_irq && !interrupt_control_reg[CTL_SENSE_ALT_A]) begin
      pending[SRC_SP1_RX] = lvl_alt_a;
    end
  end

  // power-down ignores the mask
  always_comb begin
    req = pending & interrupt_mask_reg;
    req[SRC_PWD] = pending[SRC_PWD];
  end

  // nesting lets only strictly higher levels in; sequential blocks all while busy
  always_comb begin
    preempt_ok = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      preempt_ok[i] = 1'b1;
      for (int j = 0; j <= i; j++) begin
        if (active[j]) begin
          preempt_ok[i] = 1'b0;
        end
      end
    end
    if (!interrupt_control_reg[CTL_NEST] && (active != '0)) begin
      preempt_ok = '0;
    end
  end

  assign masked = (global_enable && !mask_block) ? (req & preempt_ok) : '0;

  // lowest index wins
  always_comb begin
    sel_onehot = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (masked[i]) begin
        sel_onehot = '0;
        sel_onehot[i] = 1'b1;
      end
    end
  end

  assign any_sel = (sel_onehot != '0);

  always_comb begin
    next_vector = VEC_RESET;
    case (1'b1)
      sel_onehot[SRC_PWD]:    next_vector = VEC_PWD;
      sel_onehot[SRC_HIGH]:   next_vector = VEC_HIGH;
      sel_onehot[SRC_LVL_B]:  next_vector = VEC_LVL_B;
      sel_onehot[SRC_LVL_A]:  next_vector = VEC_LVL_A;
      sel_onehot[SRC_SP0_TX]: next_vector = VEC_SP0_TX;
      sel_onehot[SRC_SP0_RX]: next_vector = VEC_SP0_RX;
      sel_onehot[SRC_EDGE]:   next_vector = VEC_EDGE;
      sel_onehot[SRC_BYTE_DMA]:   next_vector = VEC_BYTE_DMA;
      sel_onehot[SRC_SP1_TX]: next_vector = VEC_SP1_TX;
      sel_onehot[SRC_SP1_RX]: next_vector = VEC_SP1_RX;
      sel_onehot[SRC_TIMER]:  next_vector = VEC_TIMER;
      default:                next_vector = VEC_RESET;
    endcase
  end

  // acceptance only while running; idle and slow idle wake here too
  assign int_take = any_sel && ((state == RUN) || (state == IDLE && core_clk_en)) && !stack_full;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_vector <= VEC_RESET;
    end else if (int_take) begin
      int_vector <= next_vector;
    end
  end

  // active levels, popped back on return
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active <= '0;
    end else if (int_take) begin
      active <= active | sel_onehot;
    end else if (int_return) begin
      active <= active & (active - 1'b1); // newest level is the highest one
    end
  end

  // status stack pushed on each take, popped on return
  status_stack #(.W(7), .DEPTH(STACK_DEPTH)) u_stack (
    .clk(clk), .sys_rst(sys_rst),
    .push(int_take), .pop(int_return && !stk_empty),
    .push_data(mode_status_reg),
    .top_data(stk_top), .empty(stk_empty), .full(stack_full)
  );

  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_mask_reg <= MASK_RESET;
      mask_block         <= 1'b0;
    end else begin
      mask_block <= mask_wr;
      if (mask_wr) begin
        interrupt_mask_reg <= mask_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_control_reg <= CTL_RESET;
    end else if (ctl_wr) begin
      interrupt_control_reg <= ctl_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_enable <= 1'b1;
    end else if (global_int_disable_instr) begin
      global_enable <= 1'b0;
    end else if (global_int_enable_instr) begin
      global_enable <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_status_reg <= MODE_STATUS_REG_RESET;
    end else if (int_return && !stk_empty) begin
      mode_status_reg <= stk_top;
    end else if (mode_status_reg_wr) begin
      mode_status_reg <= mode_status_reg_wdata;
    end
  end

  // low-power sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state         <= RUN;
      wake_cnt      <= '0;
      context_clear <= 1'b0;
    end else begin
      context_clear <= 1'b0;
      case (state)
        RUN: begin
          if (idle_instr) begin
            state <= IDLE;
          end else if (int_take && sel_onehot[SRC_PWD]) begin
            state <= PD_ENTER;
          end
        end
        IDLE: begin
          if (int_take) begin
            state <= sel_onehot[SRC_PWD] ? PD_ENTER : RUN;
          end
        end
        PD_ENTER: state <= PD_SLEEP;
        PD_SLEEP: begin
          if (fall_pwd || (force_clear_wr && force_bits[SRC_PWD])) begin
            state    <= PD_WAKE;
            wake_cnt <= osc_off_in_pd ? 14'(WAKE_XTAL - 1) : 14'(WAKE_FAST - 1);
          end
        end
        PD_WAKE: begin
          if (wake_cnt == '0) begin
            state         <= RUN;
            context_clear <= wake_context_select;
          end else begin
            wake_cnt <= wake_cnt - 1'b1;
          end
        end
        default: state <= RUN;
      endcase
    end
  end

  assign powerdown_ack = (state == PD_SLEEP) || (state == PD_WAKE);
  assign core_run      = (state == RUN);

  // slow idle divider
  always_comb begin
    case (idle_div)
      DIV_16:  clk_div_ratio = RATIO_16;
      DIV_32:  clk_div_ratio = RATIO_32;
      DIV_64:  clk_div_ratio = RATIO_64;
      DIV_128: clk_div_ratio = RATIO_128;
      default: clk_div_ratio = RATIO_1;
    endcase
  end

  logic [7:0] ratio_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ratio_q <= RATIO_1;
      div_cnt <= '0;
    end else begin
      if (state == RUN && idle_instr) begin
        ratio_q <= clk_div_ratio;
      end
      if (state != IDLE || div_cnt == ratio_q - 1'b1) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  assign core_clk_en = (state != IDLE) || (div_cnt == ratio_q - 1'b1);
endmodule

// *** tb/int_src_model.sv ***
// behavioural external interrupt sources and power-down request pin
`timescale 1ns/10ps
module int_src_model (
  // clock
  input  wire logic       clk,
  // bench requests, a set bit asserts that pin
  input  wire logic [6:0] want,
  // pins, active low
  output logic      [6:0] pins_n
);
  initial pins_n = 7'h7F;
  // released pins go to the pull-up level, never hold a stale low
  always @(posedge clk) pins_n <= #2 ~want;
endmodule

// *** tb/dsp_int_lp_monitor.sv ***
// concurrent checks on the interrupt and low-power controller ports
`timescale 1ns/10ps
module dsp_int_lp_monitor
  import int_lp_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // observed ports
  input  wire logic               mask_wr,
  input  wire logic [NUM_SRC-1:0] mask_wdata,
  input  wire logic               global_int_enable_instr,
  input  wire logic               global_int_disable_instr,
  input  wire logic [2:0]         idle_div,
  input  wire logic               int_take,
  input  wire logic [15:0]        int_vector,
  input  wire logic [7:0]         clk_div_ratio,
  input  wire logic [NUM_SRC-1:0] interrupt_mask_reg,
  input  wire logic [6:0]         mode_status_reg,
  input  wire logic               global_enable,
  input  wire logic               core_run,
  input  wire logic               core_clk_en,
  input  wire logic               context_clear
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_mask_wr;
    mask_wr ##1 1'b1;
  endsequence
  sequence s_take;
    int_take ##1 1'b1;
  endsequence
  a_mask_blocks_take: assert property (s_mask_wr |-> !int_take)
    else $error("take in cycle after mask write");
  a_disabled_no_take: assert property (!global_enable |-> !int_take)
    else $error("take while globally disabled");
  a_disable_clears: assert property (global_int_disable_instr |=> !global_enable)
    else $error("disable did not clear enable");
  a_enable_sets: assert property (global_int_enable_instr && !global_int_disable_instr |=> global_enable)
    else $error("enable did not set enable");
  a_reset_values: assert property ($fell(sys_rst) |->
    interrupt_mask_reg == MASK_RESET && mode_status_reg == MODE_STATUS_REG_RESET && global_enable)
    else $error("wrong value after reset");
  a_mask_update: assert property (mask_wr |=> interrupt_mask_reg == $past(mask_wdata))
    else $error("mask register not loaded");
  a_vector_legal: assert property (s_take |-> int_vector[1:0] == 2'h0 && int_vector != VEC_RESET
    && int_vector <= VEC_PWD)
    else $error("illegal vector after take");
  a_ratio_none: assert property (idle_div == DIV_NONE |-> clk_div_ratio == RATIO_1)
    else $error("ratio wrong for plain idle");
  a_ratio_max: assert property (idle_div == DIV_128 |-> clk_div_ratio == RATIO_128)
    else $error("ratio wrong for divide by 128");
  a_idle_clk_pulse: assert property (!core_run |-> ##[0:127] core_clk_en)
    else $error("no clock enable within largest divisor");
  a_ctx_on_wake: assert property (context_clear |-> $rose(core_run))
    else $error("context clear outside a wake");
endmodule
bind dsp_interrupt_low_power_ctrl dsp_int_lp_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .mask_wr(mask_wr),
  .mask_wdata(mask_wdata), .global_int_enable_instr(global_int_enable_instr),
  .global_int_disable_instr(global_int_disable_instr), .idle_div(idle_div), .int_take(int_take),
  .int_vector(int_vector), .clk_div_ratio(clk_div_ratio), .interrupt_mask_reg(interrupt_mask_reg),
  .mode_status_reg(mode_status_reg), .global_enable(global_enable), .core_run(core_run),
  .core_clk_en(core_clk_en), .context_clear(context_clear));

// *** tb/dsp_interrupt_low_power_ctrl_tb.sv ***
// self-checking bench for the interrupt and low-power controller
`timescale 1ns/10ps
module dsp_interrupt_low_power_ctrl_tb;
  import int_lp_pkg::*;
  logic        clk, sys_rst = 1'b1, sp1_as_irq = 1'b0, flag_out_value = 1'b0, sp1_data_rx = 1'b0;
  logic        mask_wr = 1'b0, ctl_wr = 1'b0, force_clear_wr = 1'b0, ena = 1'b0, dis = 1'b0, idle_instr = 1'b0;
  logic [12:0] drv = '0;
  logic [10:0] mask_wdata = '0, force_bits = '0, clear_bits = '0, interrupt_mask_reg;
  logic [4:0]  ctl_wdata = '0, interrupt_control_reg;
  logic [2:0]  idle_div = '0;
  logic [6:0]  pins_n, mode_status_reg, mode_status_reg_wdata = '0;
  logic [15:0] int_vector, expq [$];
  logic [7:0]  clk_div_ratio;
  logic [31:0] seed = 32'h997D9751, r;
  logic        flag_in, sp1_data_tx, int_take, core_run, core_clk_en, context_clear, powerdown_ack;
  logic        global_enable, stack_full, vchk = 1'b0, osc_off = 1'b0, wake_ctx = 1'b0;
  logic        mode_status_reg_wr = 1'b0, ret = 1'b0;
  int          err_count = 0, samples_checked = 0, s, c;
  localparam int WF = 4, WX = 8;
  // bench drive bits 0..5 internal pulses, 6..12 pins; smap gives the bit of each source
  logic [15:0] vtab [11] = '{VEC_PWD, VEC_HIGH, VEC_LVL_B, VEC_LVL_A, VEC_SP0_TX, VEC_SP0_RX, VEC_EDGE,
                             VEC_BYTE_DMA, VEC_SP1_TX, VEC_SP1_RX, VEC_TIMER};
  int          smap [11] = '{12, 6, 8, 7, 0, 1, 9, 2, 3, 4, 5};
  logic [7:0]  rtab [5] = '{RATIO_1, RATIO_16, RATIO_32, RATIO_64, RATIO_128};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  int_src_model i_src (.clk(clk), .want(drv[12:6]), .pins_n(pins_n));

  // short wake counts keep power-down exits inside the run
  dsp_interrupt_low_power_ctrl #(.WAKE_FAST(WF), .WAKE_XTAL(WX)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .high_ext_interrupt_n(pins_n[0]), .level_interrupt_a_n(pins_n[1]),
    .level_interrupt_b_n(pins_n[2]), .edge_interrupt_n(pins_n[3]), .sp1_frame_rx_n(pins_n[4]),
    .sp1_frame_tx_n(pins_n[5]), .sp1_data_rx(sp1_data_rx), .powerdown_request_pin_n(pins_n[6]),
    .sp0_tx_req(drv[0]), .sp0_rx_req(drv[1]), .byte_dma_req(drv[2]), .sp1_tx_req(drv[3]),
    .sp1_rx_req(drv[4]), .timer_req(drv[5]), .sp1_as_irq(sp1_as_irq), .flag_out_value(flag_out_value),
    .flag_in(flag_in), .sp1_data_tx(sp1_data_tx), .mask_wr(mask_wr), .mask_wdata(mask_wdata),
    .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .force_clear_wr(force_clear_wr), .force_bits(force_bits),
    .clear_bits(clear_bits), .global_int_enable_instr(ena), .global_int_disable_instr(dis),
    .mode_status_reg_wr(mode_status_reg_wr), .mode_status_reg_wdata(mode_status_reg_wdata), .int_return(ret), .idle_instr(idle_instr), .idle_div(idle_div),
    .wake_context_select(wake_ctx), .osc_off_in_pd(osc_off), .int_take(int_take), .int_vector(int_vector),
    .core_run(core_run), .core_clk_en(core_clk_en), .clk_div_ratio(clk_div_ratio),
    .context_clear(context_clear), .powerdown_ack(powerdown_ack), .interrupt_mask_reg(interrupt_mask_reg),
    .interrupt_control_reg(interrupt_control_reg), .mode_status_reg(mode_status_reg),
    .global_enable(global_enable), .stack_full(stack_full));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results();
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // vector is registered at the take edge, so it is read one cycle later;
  // a take with nothing expected compares against an impossible vector
  always @(negedge clk) begin
    if (vchk) check(int_vector, (expq.size() == 0) ? 16'hFFFF : expq.pop_front());
    vchk = !sys_rst && int_take === 1'b1;
  end

  task regw(input int w, input logic [10:0] d, input logic [10:0] cl = '0);
    case (w)
      0: begin mask_wdata = d; mask_wr = 1'b1; end
      1: begin ctl_wdata = d[4:0]; ctl_wr = 1'b1; end
      3: begin mode_status_reg_wdata = d[6:0]; mode_status_reg_wr = 1'b1; end
      default: begin force_bits = d; clear_bits = cl; force_clear_wr = 1'b1; end
    endcase
    tick(1);
    {mask_wr, ctl_wr, force_clear_wr, mode_status_reg_wr} = 4'h0;
    tick(1);
  endtask

  task start(input logic [10:0] m);
    sys_rst = 1'b1;
    drv = '0;
    expq.delete();
    tick(10);
    sys_rst = 1'b0;
    regw(1, 11'h1 << CTL_NEST);
    regw(0, m);
  endtask

  task hit(input int b);
    drv[b] = 1'b1;
    tick(1);
    drv[5:0] = '0;
  endtask

  task drain();
    for (int k = 0; k < 60 && expq.size() != 0; k++) tick(1);
    if (expq.size() != 0) begin
      err_count++;
      results();
    end
    drv = '0;
    tick(6);
  endtask

  initial begin
    start(11'h000);
    check(global_enable, 16'h1);
    check(stack_full, 16'h0);
    check(powerdown_ack, 16'h0);
    // lowest to highest, each preempting the last under nesting
    start(11'h7FF);
    for (s = SRC_TIMER; s >= SRC_PWD; s--) begin
      expq.push_back(vtab[s]);
      hit(smap[s]);
      drain();
    end
    // all internal requests in one cycle: only the highest is served
    start(11'h7FF);
    check(powerdown_ack, 16'h0);
    expq.push_back(VEC_SP0_TX);
    drv[5:0] = 6'h3F;
    tick(1);
    drv[5:0] = '0;
    drain();
    // masked request waits; power-down ignores the mask
    start(11'h000);
    hit(smap[SRC_TIMER]);
    tick(10);
    expq.push_back(VEC_TIMER);
    regw(0, 11'h1 << SRC_TIMER);
    drain();
    expq.push_back(VEC_PWD);
    hit(smap[SRC_PWD]);
    drain();
    // global disable holds a pending request back
    start(11'h7FF);
    dis = 1'b1;
    tick(1);
    dis = 1'b0;
    hit(smap[SRC_SP0_RX]);
    tick(10);
    expq.push_back(VEC_SP0_RX);
    ena = 1'b1;
    tick(1);
    ena = 1'b0;
    drain();
    // edge latch: cleared by software, then forced
    start(11'h7FF & ~(11'h1 << SRC_EDGE));
    regw(2, 11'h1 << SRC_EDGE);
    regw(2, 11'h0, 11'h1 << SRC_EDGE);
    regw(0, 11'h7FF);
    tick(10);
    expq.push_back(VEC_EDGE);
    regw(2, 11'h1 << SRC_EDGE);
    drain();
    // second serial port as interrupt pins and flags
    start(11'h7FF);
    sp1_as_irq = 1'b1;
    regw(1, (11'h1 << CTL_NEST) | 11'h3);
    expq.push_back(VEC_SP1_RX);
    hit(10);
    drain();
    expq.push_back(VEC_SP1_TX);
    hit(11);
    drain();
    repeat (4) begin
      r = rnd();
      sp1_data_rx = r[0];
      flag_out_value = r[1];
      tick(4);
      check(flag_in, r[0]);
      check(sp1_data_tx, r[1]);
    end
    // sequential mode, high pin as edge: nothing preempts until return
    start(11'h7FF);
    regw(1, 11'h1 << CTL_SENSE_HIGH);
    regw(3, 11'h5A);
    expq.push_back(VEC_TIMER);
    hit(smap[SRC_TIMER]);
    drain();
    regw(3, 11'h33);
    hit(smap[SRC_HIGH]);
    tick(10);
    expq.push_back(VEC_HIGH);
    ret = 1'b1;
    tick(1);
    ret = 1'b0;
    check(mode_status_reg, 16'h5A);
    drain();
    // software power-down woken by a second force; second pass oscillator off, clean context
    for (c = 0; c < 2; c++) begin
      start(11'h7FF);
      osc_off = c[0];
      wake_ctx = c[0];
      expq.push_back(VEC_PWD);
      regw(2, 11'h1 << SRC_PWD);
      drain();
      check(powerdown_ack, 16'h1);
      regw(2, 11'h1 << SRC_PWD);
      // one edge of the wake count passes inside the write
      for (s = 0; s < 40 && core_run !== 1'b1; s++) tick(1);
      check(16'(s), 16'(c ? WX - 1 : WF - 1));
      check(context_clear, wake_ctx);
      if (core_run !== 1'b1) results();
    end
    // divided idle halts, then an interrupt wakes it within the divisor
    start(11'h7FF);
    for (c = 0; c < 5; c++) begin
      idle_div = c[2:0];
      tick(1);
      check(clk_div_ratio, rtab[c]);
    end
    idle_div = DIV_16;
    idle_instr = 1'b1;
    tick(1);
    idle_instr = 1'b0;
    tick(3);
    check(core_run, 16'h0);
    expq.push_back(VEC_SP0_TX);
    hit(smap[SRC_SP0_TX]);
    drain();
    tick(20);
    check(core_run, 16'h1);
    results();
  end
endmodule
